// ### hw/sstm_checksum.sv
/*
 * actual checksum over the checksum-protected safety parameters.
 * purely combinational inputs, registered output; the password is not
 * an input, so a password change cannot move the checksum.
 */
`timescale 1ns/1ps
module sstm_checksum
    import sstm_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [15:0] escTime,
    input wire logic [15:0] testInterval,
    input wire logic [7:0] channelSalt,
    output logic [31:0] checksum
);
    // rotate-and-xor mix, cheap and order sensitive
    function automatic logic [31:0] mix(input logic [31:0] acc, input logic [15:0] val);
        mix = {acc[26:0], acc[31:27]} ^ {16'h0000, val} ^ {val, 16'h0000};
    endfunction

    // checksum depends on parameters only, never on password
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            checksum <= 32'h00000000;
        end else begin
            checksum <= mix(mix({24'h000000, channelSalt}, escTime), testInterval);
        end
    end
endmodule

// ### hw/sstm_defines.svh
/*
 * register offsets, field positions, reset values and timing counts
 * of the stop-transition monitor. definitions only, no logic.
 */
`ifndef SSTM_DEFINES_SVH
`define SSTM_DEFINES_SVH

// register byte addresses on the bus
`define SSTM_OFS_MODE 12'h000
`define SSTM_OFS_ESC_CTRL 12'h004
`define SSTM_OFS_ESC_POWER 12'h008
`define SSTM_OFS_TEST_INTERVAL 12'h00c
`define SSTM_OFS_SPEC_CTRL 12'h010
`define SSTM_OFS_SPEC_POWER 12'h014
`define SSTM_OFS_ACT_CTRL 12'h018
`define SSTM_OFS_ACT_POWER 12'h01c
`define SSTM_OFS_PWD_UNLOCK 12'h020
`define SSTM_OFS_PWD_NEW 12'h024
`define SSTM_OFS_PWD_CONFIRM 12'h028
`define SSTM_OFS_CONTROL 12'h02c
`define SSTM_OFS_STATUS 12'h030
`define SSTM_OFS_IRQ_STATUS 12'h034
`define SSTM_OFS_IRQ_MASK 12'h038

// commissioning mode value that holds parameters pending
`define SSTM_MODE_COMMISSION 8'h5f
`define SSTM_MODE_RESET 8'h00

// reset values of the active safety parameters
`define SSTM_ESC_RESET 16'h0000
`define SSTM_INTERVAL_RESET 16'h2000
`define SSTM_PWD_RESET 32'h00000000

// one safety monitoring cycle in ns and in clock cycles (8 ns clock)
`define SSTM_SAFETY_CYCLE_NS 32'd8000
`define SSTM_CLK_PERIOD_NS 32'd8
`define SSTM_SAFETY_CYCLE_CLKS (`SSTM_SAFETY_CYCLE_NS / `SSTM_CLK_PERIOD_NS)

// interrupt / status bit positions
`define SSTM_IRQ_CROSS 0
`define SSTM_IRQ_STOPA 1
`define SSTM_IRQ_TEST 2
`define SSTM_IRQ_ACCEPT 3
`define SSTM_IRQ_WIDTH 4

// control register bits
`define SSTM_CTL_DEFECT 0
`define SSTM_CTL_MONITOR_EN 1
`define SSTM_CTL_TEST_DONE 2

// acceptance fault codes
`define SSTM_CODE_CTRL 16'h07d0
`define SSTM_CODE_POWER 16'h07d1

`endif

// ### hw/sstm_monitor.sv
/*
 * stop-transition monitor of one drive monitoring channel with an
 * ahb-lite register slave, password gate and interrupt.
 * assumes a single ahb-lite master; the partner channel's escalation
 * time arrives on partnerEscTime from the same clock domain.
 */
`timescale 1ns/1ps
`include "sstm_defines.svh"

// Overview of operation
// - written safety parameters stay pending until mode leaves value 95.
// - channel defect from cross-check enters the cross-check fault stop.
// - after transition time, escalate to pulse-inhibit stop and raise fault.
// - transition time resets to zero, meaning immediate escalation.
// - both channel transition times cross-checked, one cycle difference tolerated.
// - dormant test interval expiry raises the test-required alarm.
// - actual checksum per channel is readable, read-only.
// - new password valid only after identical write to confirmation.
// - safety parameter writes refused unless current password unlocked.
// - password change leaves checksums untouched.
// - leaving commissioning with checksum mismatch raises fault, mode stays.
module sstm_monitor
    import sstm_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [15:0] partnerEscTime,
    output logic stopAActive,
    output logic testAlarm,
    output logic irq
);
    import sstm_pkg::*;

    typedef struct packed {
        sstm_ahb_req_t req;
        logic [31:0] rdata;
        logic [7:0] mode;
        sstm_params_t pend;
        sstm_params_t act;
        logic [31:0] pwd;
        logic [31:0] newPwd;
        logic newPwdValid;
        logic unlocked;
        logic [2:0] ctl;
        sstm_stop_t stop;
        logic [15:0] faultCode;
        logic [3:0] irqStat;
        logic [3:0] irqMask;
        logic stopAOut;
        logic alarmOut;
        logic irqOut;
    } sstm_state_t;

    sstm_state_t st;
    sstm_state_t next_st;
    logic stopTimerDone;
    logic testTimerDone;
    logic [31:0] actualSum;
    logic [3:0] events;
    logic crossMismatch;

    function automatic logic [15:0] absDiff(input logic [15:0] a, input logic [15:0] b);
        absDiff = (a > b) ? (a - b) : (b - a);
    endfunction

    // escalation timer runs while in the cross-check fault stop
    sstm_timer stopTimer (
        .ref_clk(ref_clk),
        .reset(reset),
        .start(st.stop != SSTM_RUN),
        .loadCycles(st.act.escCtrl),
        .expired(stopTimerDone)
    );

    // dormant test timer restarts on each confirmed test
    sstm_timer testTimer (
        .ref_clk(ref_clk),
        .reset(reset),
        .start(!st.ctl[`SSTM_CTL_TEST_DONE]),
        .loadCycles(st.act.testInterval),
        .expired(testTimerDone)
    );

    sstm_checksum sum (
        .ref_clk(ref_clk),
        .reset(reset),
        .escTime(st.act.escCtrl),
        .testInterval(st.act.testInterval),
        .channelSalt(8'h01),
        .checksum(actualSum)
    );

    // tolerance of one monitoring cycle between channels
    assign crossMismatch = absDiff(st.act.escCtrl, partnerEscTime) > 16'h0001;

    always_comb begin
        next_st = st;
        events = 4'h0;
        next_st.ctl[`SSTM_CTL_TEST_DONE] = 1'b0;
        // bus address phase capture
        if (hready) begin
            next_st.req.sel = hsel && htrans[1];
            next_st.req.trans = htrans;
            next_st.req.addr = haddr;
            next_st.req.write = hwrite;
            next_st.req.size = hsize;
        end
        // data phase of a write
        if (st.req.sel && st.req.write) begin
            case (st.req.addr)
                `SSTM_OFS_MODE: begin
                    next_st.mode = hwdata[7:0];
                end
                `SSTM_OFS_ESC_CTRL: begin
                    if (st.unlocked) next_st.pend.escCtrl = hwdata[15:0];
                end
                `SSTM_OFS_ESC_POWER: begin
                    if (st.unlocked) next_st.pend.escPower = hwdata[15:0];
                end
                `SSTM_OFS_TEST_INTERVAL: begin
                    if (st.unlocked) next_st.pend.testInterval = hwdata[15:0];
                end
                `SSTM_OFS_SPEC_CTRL: begin
                    if (st.unlocked) next_st.pend.specCtrl = hwdata;
                end
                `SSTM_OFS_SPEC_POWER: begin
                    if (st.unlocked) next_st.pend.specPower = hwdata;
                end
                `SSTM_OFS_PWD_UNLOCK: begin
                    next_st.unlocked = (hwdata == st.pwd);
                end
                `SSTM_OFS_PWD_NEW: begin
                    next_st.newPwd = hwdata;
                    next_st.newPwdValid = st.unlocked;
                end
                `SSTM_OFS_PWD_CONFIRM: begin
                    if (st.newPwdValid && hwdata == st.newPwd) begin
                        next_st.pwd = hwdata;
                    end
                    next_st.newPwdValid = 1'b0;
                end
                `SSTM_OFS_CONTROL: begin
                    next_st.ctl = hwdata[2:0];
                end
                `SSTM_OFS_IRQ_MASK: begin
                    next_st.irqMask = hwdata[3:0];
                end
                default: begin
                end
            endcase
        end
        // leaving commissioning applies pending values after checksum check
        if (st.mode == `SSTM_MODE_COMMISSION && st.req.sel && st.req.write
                && st.req.addr == `SSTM_OFS_MODE
                && hwdata[7:0] != `SSTM_MODE_COMMISSION) begin
            if (st.ctl[`SSTM_CTL_MONITOR_EN] && st.pend.specCtrl != actualSum) begin
                next_st.mode = `SSTM_MODE_COMMISSION;
                next_st.faultCode = `SSTM_CODE_CTRL;
                events[`SSTM_IRQ_ACCEPT] = 1'b1;
            end else if (st.ctl[`SSTM_CTL_MONITOR_EN] && st.pend.specPower != actualSum) begin
                next_st.mode = `SSTM_MODE_COMMISSION;
                next_st.faultCode = `SSTM_CODE_POWER;
                events[`SSTM_IRQ_ACCEPT] = 1'b1;
            end else begin
                next_st.act = st.pend;
                next_st.faultCode = 16'h0000;
            end
        end
        // stop sequence
        case (st.stop)
            SSTM_RUN: begin
                if (st.ctl[`SSTM_CTL_DEFECT] || crossMismatch) begin
                    next_st.stop = SSTM_STOP_F;
                    events[`SSTM_IRQ_CROSS] = 1'b1;
                end
            end
            SSTM_STOP_F: begin
                if (stopTimerDone) begin
                    next_st.stop = SSTM_STOP_A;
                    events[`SSTM_IRQ_STOPA] = 1'b1;
                end
            end
            SSTM_STOP_A: begin
                if (!st.ctl[`SSTM_CTL_DEFECT] && !crossMismatch) begin
                    next_st.stop = SSTM_RUN;
                end
            end
            default: begin
                next_st.stop = SSTM_RUN;
            end
        endcase
        if (testTimerDone && !st.alarmOut) begin
            events[`SSTM_IRQ_TEST] = 1'b1;
        end
        // status read clears, a new event in the same cycle wins
        if (st.req.sel && !st.req.write && st.req.addr == `SSTM_OFS_IRQ_STATUS) begin
            next_st.irqStat = 4'h0;
        end
        next_st.irqStat = next_st.irqStat | events;
        // read data for the next data phase
        next_st.rdata = 32'h00000000;
        if (hready && hsel && htrans[1] && !hwrite) begin
            case (haddr)
                `SSTM_OFS_MODE: next_st.rdata = {24'h000000, st.mode};
                `SSTM_OFS_ESC_CTRL: next_st.rdata = {16'h0000, st.act.escCtrl};
                `SSTM_OFS_ESC_POWER: next_st.rdata = {16'h0000, st.act.escPower};
                `SSTM_OFS_TEST_INTERVAL: next_st.rdata = {16'h0000, st.act.testInterval};
                `SSTM_OFS_SPEC_CTRL: next_st.rdata = st.act.specCtrl;
                `SSTM_OFS_SPEC_POWER: next_st.rdata = st.act.specPower;
                `SSTM_OFS_ACT_CTRL: next_st.rdata = actualSum;
                `SSTM_OFS_ACT_POWER: next_st.rdata = actualSum;
                `SSTM_OFS_CONTROL: next_st.rdata = {29'h00000000, st.ctl};
                `SSTM_OFS_STATUS: next_st.rdata = {st.faultCode, 11'h000,
                    st.unlocked, st.alarmOut, st.stopAOut, st.stop};
                `SSTM_OFS_IRQ_STATUS: next_st.rdata = {28'h0000000, next_st.irqStat};
                `SSTM_OFS_IRQ_MASK: next_st.rdata = {28'h0000000, st.irqMask};
                default: next_st.rdata = 32'h00000000;
            endcase
        end
        next_st.stopAOut = (next_st.stop == SSTM_STOP_A);
        next_st.alarmOut = testTimerDone;
        next_st.irqOut = |(next_st.irqStat & next_st.irqMask);
    end

    // one register holds the whole state
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            st <= '0;
            st.mode <= `SSTM_MODE_RESET;
            st.act.escCtrl <= `SSTM_ESC_RESET;
            st.act.escPower <= `SSTM_ESC_RESET;
            st.act.testInterval <= `SSTM_INTERVAL_RESET;
            st.pend.testInterval <= `SSTM_INTERVAL_RESET;
            st.pwd <= `SSTM_PWD_RESET;
            st.stop <= SSTM_RUN;
        end else begin
            st <= next_st;
        end
    end

    assign hrdata = st.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign stopAActive = st.stopAOut;
    assign testAlarm = st.alarmOut;
    assign irq = st.irqOut;

    // cross-check fault stop is entered one cycle after a defect
    property defectEnter;
        @(posedge ref_clk) disable iff (reset)
        (st.stop == SSTM_RUN && st.ctl[`SSTM_CTL_DEFECT]) |=> st.stop == SSTM_STOP_F;
    endproperty
    defect_stop_a: assert property (defectEnter) else $error("defect missed");

    sequence inStopF;
        st.stop == SSTM_STOP_F;
    endsequence
    stop_escalate_a: assert property (@(posedge ref_clk) disable iff (reset)
        (inStopF and stopTimerDone) |=> stopAActive) else $error("no escalation");
    zero_delay_a: assert property (@(posedge ref_clk) disable iff (reset)
        ($rose(st.stop == SSTM_STOP_F) && st.act.escCtrl == 16'h0000)
        |-> ##[1:3] stopAActive) else $error("zero time delayed");
    cross_tol_a: assert property (@(posedge ref_clk) disable iff (reset)
        (absDiff(st.act.escCtrl, partnerEscTime) <= 16'h0001 && !st.ctl[0]
        && st.stop == SSTM_RUN) |=> st.stop == SSTM_RUN) else $error("tolerance");
    test_alarm_a: assert property (@(posedge ref_clk) disable iff (reset)
        testTimerDone |=> testAlarm) else $error("alarm missing");
    pending_hold_a: assert property (@(posedge ref_clk) disable iff (reset)
        (st.mode == `SSTM_MODE_COMMISSION && !(st.req.sel && st.req.write
        && st.req.addr == `SSTM_OFS_MODE)) |=> $stable(st.act)) else $error("applied");
    lock_gate_a: assert property (@(posedge ref_clk) disable iff (reset)
        !st.unlocked |=> $stable(st.pend.escCtrl)) else $error("locked write");
    pwd_confirm_a: assert property (@(posedge ref_clk) disable iff (reset)
        (st.pwd != $past(st.pwd)) |-> $past(st.newPwdValid)) else $error("pwd");
    sum_stable_a: assert property (@(posedge ref_clk) disable iff (reset)
        (st.act == $past(st.act) && $past(st.act) == $past(st.act, 2)) |=> $stable(actualSum))
        else $error("checksum moved");
    accept_fail_a: assert property (@(posedge ref_clk) disable iff (reset)
        events[`SSTM_IRQ_ACCEPT] |=> st.mode == `SSTM_MODE_COMMISSION)
        else $error("left mode");
endmodule

// ### hw/sstm_pkg.sv
/*
 * types of the stop-transition monitor.
 * assumes sstm_defines.svh is included by the modules that need offsets.
 */
package sstm_pkg;

    typedef enum logic [1:0] {
        SSTM_RUN = 2'b00,
        SSTM_STOP_F = 2'b01,
        SSTM_STOP_A = 2'b10
    } sstm_stop_t;

    // safety parameters, pending or active
    typedef struct packed {
        logic [15:0] escCtrl;
        logic [15:0] escPower;
        logic [15:0] testInterval;
        logic [31:0] specCtrl;
        logic [31:0] specPower;
    } sstm_params_t;

    // one ahb-lite request
    typedef struct packed {
        logic sel;
        logic [1:0] trans;
        logic [11:0] addr;
        logic write;
        logic [2:0] size;
    } sstm_ahb_req_t;

endpackage

// ### hw/sstm_timer.sv
/*
 * down counter in whole safety monitoring cycles.
 * restarts from its load value on the rising edge of start; expired is
 * a level held until start falls.
 */
`timescale 1ns/1ps
`include "sstm_defines.svh"
module sstm_timer
    import sstm_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic start,
    input wire logic [15:0] loadCycles,
    output logic expired
);
    logic startDly;
    logic [15:0] remain;
    logic [15:0] prescale;
    logic running;

    // restart on each new entry, count whole monitoring cycles
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            startDly <= 1'b0;
            remain <= 16'h0000;
            prescale <= 16'h0000;
            running <= 1'b0;
            expired <= 1'b0;
        end else begin
            startDly <= start;
            if (!start) begin
                running <= 1'b0;
                expired <= 1'b0;
            end else if (!startDly) begin
                remain <= loadCycles;
                prescale <= 16'h0000;
                running <= (loadCycles != 16'h0000);
                expired <= (loadCycles == 16'h0000);
            end else if (running) begin
                if (prescale == 16'(`SSTM_SAFETY_CYCLE_CLKS - 1)) begin
                    prescale <= 16'h0000;
                    remain <= remain - 16'h0001;
                    if (remain == 16'h0001) begin
                        running <= 1'b0;
                        expired <= 1'b1;
                    end
                end else begin
                    prescale <= prescale + 16'h0001;
                end
            end
        end
    end
endmodule

// ### testbench/sstm_partner_channel.sv
/*
 * second monitoring channel, reduced to the transition time that it
 * offers to the cross-check.
 * assumes the same clock domain and reset as the monitor under test.
 */
`timescale 1ns/1ps
module sstm_partner_channel
    import sstm_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [15:0] escSet,
    output logic [15:0] partnerEscTime
);
    // registered like a real channel, so a change lands one cycle late
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            partnerEscTime <= 16'h0000;
        end else begin
            partnerEscTime <= escSet;
        end
    end
endmodule

// ### testbench/tb_top.sv
/*
 * self-checking bench of the stop-transition monitor, one task per case.
 * assumes a zero-wait ahb-lite slave and the partner channel model.
 */
`timescale 1ns/1ps
`include "sstm_defines.svh"
module tb_top;
    import sstm_pkg::*;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic hsel = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'b010;
    logic [31:0] hwdata = 32'h00000000;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [15:0] partnerSet = 16'h0000;
    logic [15:0] partnerEscTime;
    logic stopAActive;
    logic testAlarm;
    logic irq;
    logic [31:0] rd;
    logic [31:0] act;
    int n;
    int n_fail = 0;
    int tests_run = 0;

    // single slave, so its ready is the bus ready
    sstm_monitor i_dut (.ref_clk(ref_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .partnerEscTime(partnerEscTime), .stopAActive(stopAActive),
        .testAlarm(testAlarm), .irq(irq));
    sstm_partner_channel i_partner (.ref_clk(ref_clk), .reset(reset),
        .escSet(partnerSet), .partnerEscTime(partnerEscTime));

    initial begin
        forever #4 ref_clk = ~ref_clk;
    end

    task automatic wrap_up;
        if (n_fail == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    // address phase held until ready, then data phase held until ready
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        int k;
        k = 0;
        @(posedge ref_clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        do begin
            @(posedge ref_clk);
            k++;
        end while (hreadyout !== 1'b1 && k < 50);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do begin
            @(posedge ref_clk);
            k++;
        end while (hreadyout !== 1'b1 && k < 50);
        q = hrdata;
        if (k >= 50) chk(32'h0, 32'h1);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask

    task automatic rdv(input logic [11:0] a, output logic [31:0] q);
        xfer(1'b0, a, 32'h00000000, q);
    endtask

    // cycles until stop a (alarm=0) or the test alarm (alarm=1) rises
    task automatic wait_rise(input logic alarm, input int lim, output int cnt);
        cnt = 0;
        while (cnt < lim && ((alarm ? testAlarm : stopAActive) !== 1'b1)) begin
            @(posedge ref_clk);
            cnt++;
        end
    endtask

    task automatic t_reset;
        chk({31'b0, hreadyout}, 32'h1);
        chk({31'b0, hresp}, 32'h0);
        rdv(`SSTM_OFS_MODE, rd);
        chk(rd, 32'h0);
        rdv(`SSTM_OFS_ESC_CTRL, rd);
        chk(rd, 32'h0);
        rdv(`SSTM_OFS_ESC_POWER, rd);
        chk(rd, 32'h0);
        rdv(`SSTM_OFS_TEST_INTERVAL, rd);
        chk(rd, 32'h2000);
        rdv(`SSTM_OFS_STATUS, rd);
        chk(rd, 32'h0);
        chk({31'b0, irq}, 32'h0);
    endtask

    // a write while locked must leave the parameter alone
    task automatic t_locked;
        wr(`SSTM_OFS_ESC_CTRL, 32'h5);
        wr(`SSTM_OFS_MODE, 32'h5f);
        wr(`SSTM_OFS_MODE, 32'h0);
        rdv(`SSTM_OFS_ESC_CTRL, rd);
        chk(rd, 32'h0);
    endtask

    task automatic t_escalate;
        wr(`SSTM_OFS_PWD_UNLOCK, 32'h0);
        rdv(`SSTM_OFS_STATUS, rd);
        chk({31'b0, rd[4]}, 32'h1);
        wr(`SSTM_OFS_MODE, 32'h5f);
        wr(`SSTM_OFS_ESC_CTRL, 32'h2);
        wr(`SSTM_OFS_ESC_POWER, 32'h2);
        // pending time of 2 must not act yet: zero still escalates at once
        wr(`SSTM_OFS_CONTROL, 32'h1);
        wait_rise(1'b0, 20, n);
        chk({31'b0, n < 20}, 32'h1);
        rdv(`SSTM_OFS_IRQ_STATUS, rd);
        chk({30'b0, rd[1:0]}, 32'h3);
        wr(`SSTM_OFS_CONTROL, 32'h0);
        repeat (5) @(posedge ref_clk);
        chk({31'b0, stopAActive}, 32'h0);
        // step the partner so both channels stay within one cycle while applying
        partnerSet <= 16'h0001;
        repeat (2) @(posedge ref_clk);
        wr(`SSTM_OFS_MODE, 32'h0);
        partnerSet <= 16'h0002;
        repeat (20) @(posedge ref_clk);
        rdv(`SSTM_OFS_IRQ_STATUS, rd);
        rdv(`SSTM_OFS_ESC_CTRL, rd);
        chk(rd, 32'h2);
        wr(`SSTM_OFS_CONTROL, 32'h1);
        rdv(`SSTM_OFS_STATUS, rd);
        chk({30'b0, rd[1:0]}, {30'b0, SSTM_STOP_F});
        wait_rise(1'b0, 4000, n);
        chk({31'b0, n >= 1990 && n <= 3010}, 32'h1);
        rdv(`SSTM_OFS_STATUS, rd);
        chk({29'b0, rd[2:0]}, {29'b0, 1'b1, SSTM_STOP_A});
        // mask gates the level, read clears the sticky bit
        wr(`SSTM_OFS_IRQ_MASK, 32'h2);
        repeat (2) @(posedge ref_clk);
        chk({31'b0, irq}, 32'h1);
        wr(`SSTM_OFS_IRQ_MASK, 32'h0);
        repeat (2) @(posedge ref_clk);
        chk({31'b0, irq}, 32'h0);
        wr(`SSTM_OFS_CONTROL, 32'h0);
        repeat (5) @(posedge ref_clk);
        rdv(`SSTM_OFS_IRQ_STATUS, rd);
        wr(`SSTM_OFS_IRQ_MASK, 32'h2);
        repeat (2) @(posedge ref_clk);
        chk({31'b0, irq}, 32'h0);
        chk({31'b0, stopAActive}, 32'h0);
    endtask

    // one cycle apart is tolerated, two is a channel defect
    task automatic t_cross;
        partnerSet <= 16'h0003;
        repeat (2200) @(posedge ref_clk);
        rdv(`SSTM_OFS_IRQ_STATUS, rd);
        chk({31'b0, rd[0]}, 32'h0);
        partnerSet <= 16'h0004;
        repeat (1100) @(posedge ref_clk);
        rdv(`SSTM_OFS_IRQ_STATUS, rd);
        chk({31'b0, rd[0]}, 32'h1);
        partnerSet <= 16'h0002;
        repeat (1100) @(posedge ref_clk);
        rdv(`SSTM_OFS_IRQ_STATUS, rd);
        chk({31'b0, stopAActive}, 32'h0);
    endtask

    task automatic t_interval;
        wr(`SSTM_OFS_MODE, 32'h5f);
        wr(`SSTM_OFS_TEST_INTERVAL, 32'h2);
        wr(`SSTM_OFS_MODE, 32'h0);
        wr(`SSTM_OFS_CONTROL, 32'h4);
        wait_rise(1'b1, 4000, n);
        chk({31'b0, n >= 1000 && n <= 3010}, 32'h1);
        rdv(`SSTM_OFS_IRQ_STATUS, rd);
        chk({31'b0, rd[2]}, 32'h1);
        wr(`SSTM_OFS_CONTROL, 32'h4);
        repeat (3) @(posedge ref_clk);
        chk({31'b0, testAlarm}, 32'h0);
        wait_rise(1'b1, 4000, n);
        chk({31'b0, n >= 1000 && n <= 3010}, 32'h1);
    endtask

    task automatic t_checksum;
        rdv(`SSTM_OFS_ACT_CTRL, act);
        wr(`SSTM_OFS_ACT_CTRL, ~act);
        rdv(`SSTM_OFS_ACT_CTRL, rd);
        chk(rd, act);
        wr(`SSTM_OFS_CONTROL, 32'h2);
        wr(`SSTM_OFS_MODE, 32'h5f);
        wr(`SSTM_OFS_SPEC_CTRL, act + 32'h1);
        wr(`SSTM_OFS_MODE, 32'h0);
        rdv(`SSTM_OFS_MODE, rd);
        chk(rd, 32'h5f);
        rdv(`SSTM_OFS_STATUS, rd);
        chk({16'h0, rd[31:16]}, {16'h0, `SSTM_CODE_CTRL});
        rdv(`SSTM_OFS_IRQ_STATUS, rd);
        chk({31'b0, rd[3]}, 32'h1);
        wr(`SSTM_OFS_SPEC_CTRL, act);
        rdv(`SSTM_OFS_ACT_POWER, rd);
        wr(`SSTM_OFS_SPEC_POWER, rd);
        wr(`SSTM_OFS_MODE, 32'h0);
        rdv(`SSTM_OFS_MODE, rd);
        chk(rd, 32'h0);
        // password swap, then wrong and right unlock values
        wr(`SSTM_OFS_PWD_NEW, 32'h1234);
        wr(`SSTM_OFS_PWD_CONFIRM, 32'h1234);
        rdv(`SSTM_OFS_ACT_CTRL, rd);
        chk(rd, act);
        wr(`SSTM_OFS_PWD_UNLOCK, 32'h9);
        rdv(`SSTM_OFS_STATUS, rd);
        chk({31'b0, rd[4]}, 32'h0);
        wr(`SSTM_OFS_PWD_UNLOCK, 32'h1234);
        rdv(`SSTM_OFS_STATUS, rd);
        chk({31'b0, rd[4]}, 32'h1);
        wr(`SSTM_OFS_PWD_NEW, 32'h55);
        wr(`SSTM_OFS_PWD_CONFIRM, 32'h56);
        wr(`SSTM_OFS_PWD_UNLOCK, 32'h55);
        rdv(`SSTM_OFS_STATUS, rd);
        chk({31'b0, rd[4]}, 32'h0);
    endtask

    // watchdog well past the longest expected run
    initial begin
        #600000;
        n_fail++;
        wrap_up();
    end

    initial begin
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        t_reset();
        t_locked();
        t_escalate();
        t_cross();
        t_interval();
        t_checksum();
        wrap_up();
    end
endmodule
